// file: verilog/erc_pkg.sv
// Package for the event report column encoder: symbols and input/output bundles
package erc_pkg;

    // Column symbol codes, ASCII
    localparam logic [7:0] SYM_BLANK   = 8'h20;
    localparam logic [7:0] SYM_STAR    = 8'h2A;
    localparam logic [7:0] SYM_RESET   = 8'h72;  // r
    localparam logic [7:0] SYM_PICKUP  = 8'h70;  // p
    localparam logic [7:0] SYM_TRIP    = 8'h54;  // T
    localparam logic [7:0] SYM_RSTAFT  = 8'h31;  // 1
    localparam logic [7:0] SYM_BOTH    = 8'h62;  // b
    localparam logic [7:0] SYM_CHAN_X  = 8'h58;  // X
    localparam logic [7:0] SYM_CHAN_Y  = 8'h59;  // Y

    // Column counts
    localparam int NUM_DIFF_COLS = 11;
    localparam int NUM_RX_COLS   = 4;
    localparam int NUM_TX_COLS   = 2;
    localparam int NUM_COLS      = 34;

    // Column positions inside the output row
    localparam int COL_DIFF_BASE = 0;
    localparam int COL_TOC_PH    = 11;
    localparam int COL_INST_PH   = 12;
    localparam int COL_TOC_GND   = 13;
    localparam int COL_INST_GND  = 14;
    localparam int COL_TOC_NEG   = 15;
    localparam int COL_INST_NEG  = 16;
    localparam int COL_FSEL_A    = 17;
    localparam int COL_FSEL_B    = 18;
    localparam int COL_FSEL_C    = 19;
    localparam int COL_FSEL_EN   = 20;
    localparam int COL_BLK_GND   = 21;
    localparam int COL_BLK_NEG   = 22;
    localparam int COL_RX_BASE   = 23;
    localparam int COL_TX_BASE   = 27;
    localparam int COL_RX_VALID  = 29;
    localparam int COL_FSEL_BITS = 30;

    // Time-overcurrent element state bits
    typedef struct packed {
        logic pickup;     // Picked up
        logic timedOut;   // Timed out
        logic resetting;  // Timing to reset
    } erc_toc_t;

    // Instantaneous/definite-time element bits
    typedef struct packed {
        logic pickup;     // Picked up
        logic trip;       // Trip element
    } erc_inst_t;

    // Channel X/Y bit pair
    typedef struct packed {
        logic chanX;      // Channel X copy
        logic chanY;      // Channel Y copy
    } erc_pair_t;

    // Fault type bits
    typedef struct packed {
        logic aGnd;
        logic bGnd;
        logic cGnd;
        logic aB;
        logic bC;
        logic cA;
        logic threePhase;
    } erc_ftype_t;

    // Element bits sampled once per processing interval
    typedef struct packed {
        logic [NUM_DIFF_COLS-1:0] diffBits;  // Diff elements and restraints
        erc_toc_t                 tocPh;
        erc_toc_t                 tocGnd;
        erc_toc_t                 tocNeg;
        erc_inst_t                instPh;
        erc_inst_t                instGnd;
        erc_inst_t                instNeg;
        erc_ftype_t               faultType;
        logic                     faultSelEn;
        logic                     blockGndDiff;
        logic                     blockNegDiff;
        erc_pair_t [NUM_RX_COLS-1:0] rxBits;
        erc_pair_t [NUM_TX_COLS-1:0] txBits;
        erc_pair_t                rxValid;
    } erc_elem_t;

    // One report row of character symbols
    typedef logic [NUM_COLS-1:0][7:0] erc_row_t;

endpackage : erc_pkg

// file: verilog/erc_fault_select.sv
// Per-phase fault type select decode, registered
`timescale 1ns/1ps
module erc_fault_select (
    input  wire logic              mclk,       // Processing clock
    input  wire logic              rst_n,      // Async reset, active low
    input  wire erc_pkg::erc_ftype_t faultType, // Fault type bits
    output logic [2:0]             faultSel    // Select bits C,B,A
);
    import erc_pkg::*;

    // Phase selects are ORs of the fault types that involve that phase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            faultSel <= 3'h0;
        end else begin
            faultSel[0] <= faultType.aGnd | faultType.aB | faultType.cA
                           | faultType.threePhase;
            faultSel[1] <= faultType.bGnd | faultType.aB | faultType.bC
                           | faultType.threePhase;
            faultSel[2] <= faultType.cGnd | faultType.bC | faultType.cA
                           | faultType.threePhase;
        end
    end

endmodule : erc_fault_select

// file: verilog/erc_column_encoder.sv
// Event report column encoder: element bits to one row of column symbols
//
// Behaviour
// - Phase time-overcurrent column: r resetting, p timing, T timed out, 1 reset after.
// - Ground time-overcurrent column uses the same four-symbol encoding.
// - Negative-sequence time-overcurrent column uses the same four-symbol encoding.
// - Phase instantaneous column: T on trip, else star on pickup.
// - Ground instantaneous column: T on trip, else star on pickup.
// - Negative-sequence instantaneous column: T on trip, else star on pickup.
// - Phase A select asserted on A-ground, A-B, C-A or three-phase; star shown.
// - Phase B select asserted on B-ground, A-B, B-C or three-phase; star shown.
// - Phase C select asserted on C-ground, B-C, C-A or three-phase; star shown.
// - Receive columns: b both channels, X only X, Y only Y.
// - Transmit columns one and two: b both, X only X, Y only Y.
// - Receive-valid column: b both valid, X only X, Y only Y.
`timescale 1ns/1ps
module erc_column_encoder (
    input  wire logic               mclk,      // Processing clock, 125 MHz
    input  wire logic               rst_n,     // Async reset, active low
    input  wire logic               sampleVld, // Element bits valid this cycle
    input  wire erc_pkg::erc_elem_t elemBits,  // Element state bits
    output erc_pkg::erc_row_t       rowSyms,   // Encoded column symbols
    output logic                    rowVld,    // Row valid pulse
    output logic [2:0]              faultSel   // Fault select bits C,B,A
);
    import erc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Symbol functions

    // Time-overcurrent: timed-out wins over plain pickup
    function automatic logic [7:0] encToc(input erc_toc_t t);
        logic [7:0] s;
        s = SYM_BLANK;
        if (t.timedOut && t.resetting) begin
            s = SYM_RSTAFT;
        end else if (t.timedOut) begin
            s = SYM_TRIP;
        end else if (t.resetting) begin
            s = SYM_RESET;
        end else if (t.pickup) begin
            s = SYM_PICKUP;
        end
        return s;
    endfunction : encToc

    // Instantaneous: trip wins over pickup
    function automatic logic [7:0] encInst(input erc_inst_t i);
        logic [7:0] s;
        s = SYM_BLANK;
        if (i.trip) begin
            s = SYM_TRIP;
        end else if (i.pickup) begin
            s = SYM_STAR;
        end
        return s;
    endfunction : encInst

    // Channel pair
    function automatic logic [7:0] encPair(input erc_pair_t p);
        logic [7:0] s;
        s = SYM_BLANK;
        if (p.chanX && p.chanY) begin
            s = SYM_BOTH;
        end else if (p.chanX) begin
            s = SYM_CHAN_X;
        end else if (p.chanY) begin
            s = SYM_CHAN_Y;
        end
        return s;
    endfunction : encPair

    // Single bit
    function automatic logic [7:0] encBit(input logic b);
        return b ? SYM_STAR : SYM_BLANK;
    endfunction : encBit

    ////////////////////////////////////////////////////////////////////////
    // Fault select decode

    logic [2:0] selNow;  // Registered with the row, same latency
    erc_fault_select uSel (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .faultType (elemBits.faultType),
        .faultSel  (selNow)
    );
    assign faultSel = selNow;

    ////////////////////////////////////////////////////////////////////////
    // Row encoding, one cycle after the sample

    erc_row_t rowD;
    erc_row_t rowQ;  // Row register before the select overlay

    always_comb begin
        rowD = {NUM_COLS{SYM_BLANK}};
        for (int i = 0; i < NUM_DIFF_COLS; i++) begin
            rowD[COL_DIFF_BASE + i] = encBit(elemBits.diffBits[i]);
        end
        rowD[COL_TOC_PH]   = encToc(elemBits.tocPh);
        rowD[COL_TOC_GND]  = encToc(elemBits.tocGnd);
        rowD[COL_TOC_NEG]  = encToc(elemBits.tocNeg);
        rowD[COL_INST_PH]  = encInst(elemBits.instPh);
        rowD[COL_INST_GND] = encInst(elemBits.instGnd);
        rowD[COL_INST_NEG] = encInst(elemBits.instNeg);
        rowD[COL_FSEL_EN]  = encBit(elemBits.faultSelEn);
        rowD[COL_BLK_GND]  = encBit(elemBits.blockGndDiff);
        rowD[COL_BLK_NEG]  = encBit(elemBits.blockNegDiff);
        for (int i = 0; i < NUM_RX_COLS; i++) begin
            rowD[COL_RX_BASE + i] = encPair(elemBits.rxBits[i]);
        end
        for (int i = 0; i < NUM_TX_COLS; i++) begin
            rowD[COL_TX_BASE + i] = encPair(elemBits.txBits[i]);
        end
        rowD[COL_RX_VALID] = encPair(elemBits.rxValid);
    end

    // Row register; select and spare columns leave it blank
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rowQ <= {NUM_COLS{SYM_BLANK}};
        end else begin
            rowQ <= rowD;
        end
    end

    // Select stars ride on the decoder register, so they line up with the row
    always_comb begin
        rowSyms             = rowQ;
        rowSyms[COL_FSEL_A] = encBit(selNow[0]);
        rowSyms[COL_FSEL_B] = encBit(selNow[1]);
        rowSyms[COL_FSEL_C] = encBit(selNow[2]);
    end

    // Valid pulse follows the sample by one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rowVld <= 1'b0;
        end else begin
            rowVld <= sampleVld;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    // Phase time-overcurrent symbols
    a_toc_timed_out: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(elemBits.tocPh.timedOut) && !$past(elemBits.tocPh.resetting)
        |-> rowSyms[COL_TOC_PH] == SYM_TRIP) else $error("phase toc not T");
    a_toc_ph_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.tocPh == 3'b001 |=> rowSyms[COL_TOC_PH] == SYM_RESET)
        else $error("phase toc not r");
    a_toc_ph_pick: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.tocPh == 3'b100 |=> rowSyms[COL_TOC_PH] == SYM_PICKUP)
        else $error("phase toc not p");
    a_toc_ph_after: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.tocPh.timedOut && elemBits.tocPh.resetting
        |=> rowSyms[COL_TOC_PH] == SYM_RSTAFT) else $error("phase toc not 1");
    // Ground time-overcurrent symbols
    a_toc_after_trip: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.tocGnd.timedOut && elemBits.tocGnd.resetting
        |=> rowSyms[COL_TOC_GND] == SYM_RSTAFT) else $error("ground toc not 1");
    a_toc_gnd_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.tocGnd == 3'b001 |=> rowSyms[COL_TOC_GND] == SYM_RESET)
        else $error("ground toc not r");
    a_toc_gnd_pick: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.tocGnd == 3'b100 |=> rowSyms[COL_TOC_GND] == SYM_PICKUP)
        else $error("ground toc not p");
    a_toc_gnd_trip: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.tocGnd.timedOut && !elemBits.tocGnd.resetting
        |=> rowSyms[COL_TOC_GND] == SYM_TRIP) else $error("ground toc not T");
    // Negative-sequence time-overcurrent symbols
    a_toc_neg_pick: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.tocNeg == 3'b100
        |=> rowSyms[COL_TOC_NEG] == SYM_PICKUP) else $error("neg toc not p");
    a_toc_neg_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.tocNeg == 3'b001 |=> rowSyms[COL_TOC_NEG] == SYM_RESET)
        else $error("neg toc not r");
    a_toc_neg_trip: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.tocNeg.timedOut && !elemBits.tocNeg.resetting
        |=> rowSyms[COL_TOC_NEG] == SYM_TRIP) else $error("neg toc not T");
    a_toc_neg_after: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.tocNeg.timedOut && elemBits.tocNeg.resetting
        |=> rowSyms[COL_TOC_NEG] == SYM_RSTAFT) else $error("neg toc not 1");
    // Instantaneous symbols, trip before pickup
    a_inst_trip: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.instPh.trip |=> rowSyms[COL_INST_PH] == SYM_TRIP)
        else $error("phase inst not T");
    a_inst_ph_pick: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.instPh == 2'b10 |=> rowSyms[COL_INST_PH] == SYM_STAR)
        else $error("phase inst not star");
    a_inst_gnd_pick: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.instGnd == 2'b10 |=> rowSyms[COL_INST_GND] == SYM_STAR)
        else $error("ground inst not star");
    a_inst_gnd_trip: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.instGnd.trip |=> rowSyms[COL_INST_GND] == SYM_TRIP)
        else $error("ground inst not T");
    a_inst_neg_blank: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.instNeg == 2'b00 |=> rowSyms[COL_INST_NEG] == SYM_BLANK)
        else $error("neg inst not blank");
    a_inst_neg_trip: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.instNeg.trip |=> rowSyms[COL_INST_NEG] == SYM_TRIP)
        else $error("neg inst not T");
    a_inst_neg_pick: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.instNeg == 2'b10 |=> rowSyms[COL_INST_NEG] == SYM_STAR)
        else $error("neg inst not star");
    // Phase A select bit and its star
    a_fsel_three: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.faultType.threePhase |=> faultSel == 3'h7)
        else $error("three phase select missing");
    a_fsel_a_set: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.faultType.aGnd || elemBits.faultType.aB
        || elemBits.faultType.cA || elemBits.faultType.threePhase
        |=> faultSel[0]) else $error("A select missing");
    a_fsel_a_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        !(elemBits.faultType.aGnd || elemBits.faultType.aB
        || elemBits.faultType.cA || elemBits.faultType.threePhase)
        |=> !faultSel[0]) else $error("A select stuck");
    a_fsel_a_star: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.faultType.aB |=> rowSyms[COL_FSEL_A] == SYM_STAR)
        else $error("A select not star");
    // Phase B select bit and its star
    a_fsel_b_only: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.faultType == 7'b0100000 |=> faultSel == 3'h2)
        else $error("B select wrong");
    a_fsel_b_set: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.faultType.bGnd || elemBits.faultType.aB
        || elemBits.faultType.bC || elemBits.faultType.threePhase
        |=> faultSel[1]) else $error("B select missing");
    a_fsel_b_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        !(elemBits.faultType.bGnd || elemBits.faultType.aB
        || elemBits.faultType.bC || elemBits.faultType.threePhase)
        |=> !faultSel[1]) else $error("B select stuck");
    a_fsel_b_star: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.faultType.bC |=> rowSyms[COL_FSEL_B] == SYM_STAR)
        else $error("B select not star");
    // Phase C select bit and its star
    a_fsel_ca: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.faultType == 7'b0000010 |=> faultSel == 3'h5)
        else $error("C-A select wrong");
    a_fsel_c_set: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.faultType.cGnd || elemBits.faultType.bC
        || elemBits.faultType.cA || elemBits.faultType.threePhase
        |=> faultSel[2]) else $error("C select missing");
    a_fsel_c_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        !(elemBits.faultType.cGnd || elemBits.faultType.bC
        || elemBits.faultType.cA || elemBits.faultType.threePhase)
        |=> !faultSel[2]) else $error("C select stuck");
    a_fsel_c_star: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.faultType.cGnd |=> rowSyms[COL_FSEL_C] == SYM_STAR)
        else $error("C select not star");
    // Receive bit pairs
    a_rx_both: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.rxBits[0] == 2'b11 |=> rowSyms[COL_RX_BASE] == SYM_BOTH)
        else $error("rx both not b");
    a_rx_only_x: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.rxBits[1] == 2'b10 |=> rowSyms[COL_RX_BASE + 1] == SYM_CHAN_X)
        else $error("rx only X not X");
    a_rx_only_y: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.rxBits[2] == 2'b01 |=> rowSyms[COL_RX_BASE + 2] == SYM_CHAN_Y)
        else $error("rx only Y not Y");
    a_rx_blank: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.rxBits[3] == 2'b00 |=> rowSyms[COL_RX_BASE + 3] == SYM_BLANK)
        else $error("rx idle not blank");
    // Transmit bit pairs
    a_tx_only_y: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.txBits[1] == 2'b01 |=> rowSyms[COL_TX_BASE + 1] == SYM_CHAN_Y)
        else $error("tx only Y not Y");
    a_tx_both: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.txBits[0] == 2'b11 |=> rowSyms[COL_TX_BASE] == SYM_BOTH)
        else $error("tx both not b");
    a_tx_only_x: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.txBits[0] == 2'b10 |=> rowSyms[COL_TX_BASE] == SYM_CHAN_X)
        else $error("tx only X not X");
    // Single-bit columns and unused columns
    a_diff_star: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.diffBits[0] |=> rowSyms[COL_DIFF_BASE] == SYM_STAR)
        else $error("diff bit not star");
    a_diff_blank: assert property (@(posedge mclk) disable iff (!rst_n)
        !elemBits.diffBits[10] |=> rowSyms[COL_DIFF_BASE + 10] == SYM_BLANK)
        else $error("diff bit not blank");
    a_fsel_en_star: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.faultSelEn |=> rowSyms[COL_FSEL_EN] == SYM_STAR)
        else $error("select enable not star");
    a_blk_gnd_star: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.blockGndDiff |=> rowSyms[COL_BLK_GND] == SYM_STAR)
        else $error("ground block not star");
    a_blk_neg_blank: assert property (@(posedge mclk) disable iff (!rst_n)
        !elemBits.blockNegDiff |=> rowSyms[COL_BLK_NEG] == SYM_BLANK)
        else $error("neg block not blank");
    a_spare_blank: assert property (@(posedge mclk) disable iff (!rst_n)
        rowSyms[NUM_COLS-1:COL_FSEL_BITS] == {4{SYM_BLANK}})
        else $error("spare columns not blank");
    // Receive-valid pair
    a_valid_x: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.rxValid == 2'b10 |=> rowSyms[COL_RX_VALID] == SYM_CHAN_X)
        else $error("rx valid X wrong");
    a_valid_both: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.rxValid == 2'b11 |=> rowSyms[COL_RX_VALID] == SYM_BOTH)
        else $error("rx valid b wrong");
    a_valid_y: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.rxValid == 2'b01 |=> rowSyms[COL_RX_VALID] == SYM_CHAN_Y)
        else $error("rx valid Y wrong");
    a_valid_blank: assert property (@(posedge mclk) disable iff (!rst_n)
        elemBits.rxValid == 2'b00 |=> rowSyms[COL_RX_VALID] == SYM_BLANK)
        else $error("rx valid not blank");

endmodule : erc_column_encoder

// file: test/erc_elem_source.sv
// Partner model: protection logic that presents element bits to the encoder
`timescale 1ns/1ps
module erc_elem_source (
    input  wire logic         mclk,      // Processing clock
    output erc_pkg::erc_elem_t elemBits,  // Element state bits
    output logic              sampleVld  // Sample marker
);
    import erc_pkg::*;
    ////////////////////////////////////////////////////////////////
    // Idle with all elements dropped so no column starts out set
    initial begin
        elemBits  = '0;
        sampleVld = 1'b0;
    end
    // Bits change at the falling edge, half a cycle clear of capture
    task automatic drive(input erc_elem_t e, input logic v);
        @(negedge mclk);
        elemBits  = e;
        sampleVld = v;
    endtask : drive
endmodule : erc_elem_source

// file: test/erc_column_encoder_bench.sv
// Self-checking bench for the event report column encoder
`timescale 1ns/1ps
module erc_column_encoder_bench;
    import erc_pkg::*;
    logic      mclk = 1'b0;
    logic      rst_n = 1'b0;
    erc_elem_t elemBits;
    logic      sampleVld;
    erc_row_t  rowSyms;
    logic      rowVld;
    logic [2:0] faultSel;
    int        fails = 0;
    int        checksDone = 0;
    erc_elem_t e;
    erc_row_t  blankRow;
    erc_row_t  rowExp;
    erc_toc_t  tocIn[5] = '{3'b001, 3'b100, 3'b110, 3'b011, 3'b000};
    logic [7:0] tocSym[5] = '{SYM_RESET, SYM_PICKUP, SYM_TRIP, SYM_RSTAFT, SYM_BLANK};
    erc_inst_t instIn[4] = '{2'b10, 2'b01, 2'b11, 2'b00};
    logic [7:0] instSym[4] = '{SYM_STAR, SYM_TRIP, SYM_TRIP, SYM_BLANK};
    logic [7:0] pairSym[4] = '{SYM_BLANK, SYM_CHAN_Y, SYM_CHAN_X, SYM_BOTH};
    logic [2:0] selExp[7] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h6, 3'h5, 3'h7};
    int        tocCol[3] = '{COL_TOC_PH, COL_TOC_GND, COL_TOC_NEG};
    int        instCol[3] = '{COL_INST_PH, COL_INST_GND, COL_INST_NEG};
    ////////////////////////////////////////////////////////////////
    // 125 MHz clock
    always #4 mclk = ~mclk;
    erc_elem_source u_erc_elem_source (
        .mclk      (mclk),
        .elemBits  (elemBits),
        .sampleVld (sampleVld)
    );
    erc_column_encoder u_erc_column_encoder (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .sampleVld (sampleVld),
        .elemBits  (elemBits),
        .rowSyms   (rowSyms),
        .rowVld    (rowVld),
        .faultSel  (faultSel)
    );
    ////////////////////////////////////////////////////////////////
    // Verdict, reached from the main sequence or the watchdog
    task automatic testDone();
        $display("Checks %0d, mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : testDone
    task automatic check_row(input erc_row_t exp);
        checksDone++;
        if (rowSyms !== exp) begin
            fails++;
            $display("Error at %0t: row %h, expected %h", $time, rowSyms, exp);
        end
    endtask : check_row
    task automatic check_bits(input logic [2:0] got, input logic [2:0] exp);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: bits %b, expected %b", $time, got, exp);
        end
    endtask : check_bits
    // Present a sample; its row is settled by the next falling edge
    task automatic send(input erc_elem_t s, input logic v);
        u_erc_elem_source.drive(s, v);
        @(negedge mclk);
    endtask : send
    // One column set, every other column must stay blank
    task automatic one(input erc_elem_t s, input int col, input logic [7:0] sym);
        erc_row_t exp;
        exp = blankRow;
        exp[col] = sym;
        send(s, 1'b1);
        check_row(exp);
        check_bits({2'b00, rowVld}, 3'h1);
    endtask : one
    ////////////////////////////////////////////////////////////////
    // Watchdog: the run needs a few hundred cycles at most
    initial begin
        repeat (3000) @(posedge mclk);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        testDone();
    end
    // Main sequence, back to back samples every two cycles
    initial begin
        blankRow = {NUM_COLS{SYM_BLANK}};
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        check_row(blankRow);
        check_bits(faultSel, 3'h0);
        for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 5; c++) begin
                e = '0;
                if (k == 0) e.tocPh = tocIn[c];
                else if (k == 1) e.tocGnd = tocIn[c];
                else e.tocNeg = tocIn[c];
                one(e, tocCol[k], tocSym[c]);
            end
            for (int c = 0; c < 4; c++) begin
                e = '0;
                if (k == 0) e.instPh = instIn[c];
                else if (k == 1) e.instGnd = instIn[c];
                else e.instNeg = instIn[c];
                one(e, instCol[k], instSym[c]);
            end
        end
        // Channel pairs: four receive, two transmit, receive-valid
        for (int k = 0; k < 7; k++) begin
            for (int c = 0; c < 4; c++) begin
                e = '0;
                if (k < 4) e.rxBits[k] = c[1:0];
                else if (k < 6) e.txBits[k-4] = c[1:0];
                else e.rxValid = c[1:0];
                one(e, (k < 6) ? COL_RX_BASE + k : COL_RX_VALID, pairSym[c]);
            end
        end
        // Single-bit columns one at a time
        for (int k = 0; k < 14; k++) begin
            e = '0;
            if (k < 11) e.diffBits[k] = 1'b1;
            else if (k == 11) e.faultSelEn = 1'b1;
            else if (k == 12) e.blockGndDiff = 1'b1;
            else e.blockNegDiff = 1'b1;
            one(e, (k < 11) ? k : COL_FSEL_EN + k - 11, SYM_STAR);
        end
        // Each fault type alone; the select stars follow the phases involved
        for (int k = 0; k < 7; k++) begin
            e = '0;
            e.faultType = 7'h40 >> k;
            rowExp = blankRow;
            for (int p = 0; p < 3; p++) begin
                if (selExp[k][p]) rowExp[COL_FSEL_A + p] = SYM_STAR;
            end
            send(e, 1'b1);
            check_bits(faultSel, selExp[k]);
            check_row(rowExp);
        end
        // Unmarked sample: no row pulse, select drops with the fault bits
        send('0, 1'b0);
        check_bits({2'b00, rowVld}, 3'h0);
        check_bits(faultSel, 3'h0);
        testDone();
    end
endmodule : erc_column_encoder_bench
